// [shared/pis_pkg.sv]
// package: constants, types and helpers of the init phase 2 data sequencer
package pis_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h4;
  localparam logic [3:0] ADDR_SERIAL = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // control bits
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_SYNC_BIT = 1;
  localparam int CTRL_START_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // config word: byte one at top, nominal upper nibble 0010
  localparam logic [31:0] CFG_RST = 32'h2000_0000;
  localparam logic [31:0] SERIAL_RST = 32'h0000_0000;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FIELD_LSB = 8;
  localparam int STAT_REP_LSB = 16;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // sequence constants
  // ------------------------------------------------------------
  localparam logic [3:0] K_ASYNC = 4'h8;
  localparam logic [3:0] K_SYNC = 4'h4;
  localparam logic [5:0] FLD_FIRST = 6'h0c;
  localparam logic [5:0] FLD_REV_MID = 6'h0d;
  localparam logic [5:0] FLD_REV_USER = 6'h0e;
  localparam logic [5:0] FLD_DATE0 = 6'h0f;
  localparam logic [5:0] FLD_DATE1 = 6'h10;
  localparam logic [5:0] FLD_DATE2 = 6'h11;
  localparam logic [5:0] FLD_DATE3 = 6'h12;
  localparam logic [5:0] FLD_SN_FIRST = 6'h13;
  localparam logic [5:0] FLD_SN_LAST = 6'h1a;
  localparam logic [5:0] FLD_OFS_LO = 6'h1b;
  localparam logic [5:0] FLD_OFS_HI = 6'h1c;
  localparam logic [5:0] FLD_OFS_ST = 6'h1d;
  localparam logic [5:0] FLD_ST_MID = 6'h1e;
  localparam logic [5:0] FLD_ST_HI = 6'h1f;
  localparam logic [5:0] FLD_LAST = 6'h20;
  // year counted from this base
  localparam logic [6:0] DATE_YEAR_BASE = 7'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PIS_IDLE = 2'b00,
    PIS_ID = 2'b01,
    PIS_DATA = 2'b10
  } pis_state_t;

  typedef struct packed {
    logic [7:0] device_config_byte_one;
    logic [7:0] device_config_byte_six;
    logic [7:0] device_config_byte_seven;
    logic [7:0] device_config_byte_eight;
  } pis_cfg_t;

  typedef struct packed {
    logic [9:0] raw_offset;
    logic [9:0] average_selftest_value;
    logic st1_done;
    logic st2_done;
  } pis_meas_t;

  typedef struct packed {
    logic is_data;
    logic [5:0] field;
    logic [3:0] nibble;
  } pis_tx_t;

  // nibble address of a field: field number less one, low four bits
  function automatic logic [3:0] nib_addr(input logic [5:0] field);
    logic [5:0] d;
    d = field - 6'h01;
    return d[3:0];
  endfunction : nib_addr

  // packed date {year[6:0], month[3:0], day[4:0]}
  function automatic logic [15:0] julian_pack(input logic [7:0] b7,
                                              input logic [7:0] b8);
    logic [6:0] julian_year_bits;
    logic [3:0] julian_month_bits;
    logic [4:0] julian_day_bits;
    julian_year_bits = DATE_YEAR_BASE + {3'h0, b7[7:4]};
    julian_month_bits = b7[3:0];
    julian_day_bits = b8[4:0];
    return {julian_year_bits, julian_month_bits, julian_day_bits};
  endfunction : julian_pack

endpackage : pis_pkg

// [hw/pis_nibble_mux.sv]
// data nibble selection for fields twelve to thirty-two
`timescale 1ns/1ps
`default_nettype none

module pis_nibble_mux #(
  parameter logic [3:0] REV_HI = 4'h0,
  parameter logic [3:0] REV_MID = 4'h0
) (
  // field being sent
  input wire logic [5:0] field,
  // sources
  input wire pis_pkg::pis_cfg_t cfg,
  input wire logic [31:0] serial,
  input wire pis_pkg::pis_meas_t meas,
  input wire logic ext_en,
  // result
  output logic [3:0] nibble
);

  // ------------------------------------------------------------
  // selection
  // ------------------------------------------------------------
  logic [15:0] jd;   // packed date
  logic [9:0] ofs;   // offset, zero until phase one done
  logic [9:0] avg;   // self-test, zero until phase two done
  logic [5:0] sn_d;  // distance into serial fields
  logic [7:0] sbyte; // selected serial byte

  always_comb begin
    jd = pis_pkg::julian_pack(cfg.device_config_byte_seven,
                              cfg.device_config_byte_eight);
    // unfinished results go out as zero
    ofs = meas.st1_done ? meas.raw_offset : 10'h000;
    avg = meas.st2_done ? meas.average_selftest_value : 10'h000;
    sn_d = field - pis_pkg::FLD_SN_FIRST;
    sbyte = serial[{sn_d[2:1], 3'h0} +: 8];
    nibble = 4'h0;
    case (field)
      pis_pkg::FLD_FIRST: nibble = REV_HI;
      pis_pkg::FLD_REV_MID: nibble = REV_MID;
      pis_pkg::FLD_REV_USER: nibble = cfg.device_config_byte_six[3:0];
      pis_pkg::FLD_DATE0: nibble = jd[15:12];
      pis_pkg::FLD_DATE1: nibble = jd[11:8];
      pis_pkg::FLD_DATE2: nibble = jd[7:4];
      pis_pkg::FLD_DATE3: nibble = jd[3:0];
      // measured data and last field, gated by extension enable
      pis_pkg::FLD_OFS_LO: nibble = ext_en ? ofs[3:0] : 4'h0;
      pis_pkg::FLD_OFS_HI: nibble = ext_en ? ofs[7:4] : 4'h0;
      pis_pkg::FLD_OFS_ST: nibble = ext_en ? {avg[1:0], ofs[9:8]} : 4'h0;
      pis_pkg::FLD_ST_MID: nibble = ext_en ? avg[5:2] : 4'h0;
      pis_pkg::FLD_ST_HI: nibble = ext_en ? avg[9:6] : 4'h0;
      pis_pkg::FLD_LAST: begin
        nibble = ext_en ? cfg.device_config_byte_one[7:4] : 4'h0;
      end
      default: begin
        if (field >= pis_pkg::FLD_SN_FIRST &&
            field <= pis_pkg::FLD_SN_LAST) begin
          nibble = sn_d[0] ? sbyte[3:0] : sbyte[7:4];
        end
      end
    endcase
  end

endmodule : pis_nibble_mux

`default_nettype wire

// [hw/pis_sequencer.sv]
// init phase 2 data sequencer, fields twelve to thirty-two, axi4-lite
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pis_sequencer #(
  parameter logic [3:0] REV_HI = 4'h0,  // factory revision nibble
  parameter logic [3:0] REV_MID = 4'h0  // factory revision nibble
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // axi4-lite write
  input wire logic [pis_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [pis_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sequence control from phase 2 front half
  input wire logic seq_start,
  input wire logic slot_tick,
  input wire pis_pkg::pis_meas_t meas,
  // transmissions
  output logic tx_valid,
  output pis_pkg::pis_tx_t tx,
  output logic seq_busy,
  output logic seq_done
);

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [31:0] ctrl_r;          // extension, sync mode
  pis_pkg::pis_cfg_t cfg_r;     // config bytes
  logic [31:0] serial_r;        // serial bytes
  logic [pis_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic start_r;                // software start pulse
  pis_pkg::pis_state_t state_r;
  logic [5:0] field_r;          // field number being sent
  logic [3:0] rep_r;            // repetition counter
  logic [3:0] k_r;              // repeats, latched at start
  logic [3:0] nibble;           // selected data nibble
  logic aw_take;
  logic w_take;
  logic wr_commit;
  logic ar_take;
  logic start_go;
  logic tick_go;
  logic last_rep;
  logic ext_en;

  assign ext_en = ctrl_r[pis_pkg::CTRL_EXT_BIT];
  // aw held while awready low, same for w
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_commit = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign start_go = (seq_start | start_r) & (state_r == pis_pkg::PIS_IDLE);
  assign tick_go = slot_tick & (state_r != pis_pkg::PIS_IDLE);
  assign last_rep = (rep_r == k_r - 4'h1);

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ------------------------------------------------------------
  // write channel: aw and w caught in either order
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pis_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_commit) begin
        // both halves held: answer and reopen on the same edge
        s_axi_bvalid <= 1'b1;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        // status is read-only, refuse writes there
        if (awaddr_r[1:0] != 2'h0 || awaddr_r == pis_pkg::ADDR_STATUS) begin
          s_axi_bresp <= pis_pkg::RESP_SLVERR;
        end else begin
          s_axi_bresp <= pis_pkg::RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // register file writes
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= pis_pkg::CTRL_RST;
      cfg_r <= pis_pkg::CFG_RST;
      serial_r <= pis_pkg::SERIAL_RST;
      start_r <= 1'b0;
    end else if (ce) begin
      start_r <= 1'b0;
      if (wr_commit) begin
        case (awaddr_r)
          pis_pkg::ADDR_CTRL: begin
            ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0003;
            // start bit is a pulse, never stored
            start_r <= wstrb_r[0] & wdata_r[pis_pkg::CTRL_START_BIT];
          end
          pis_pkg::ADDR_CFG: cfg_r <= merge(cfg_r, wdata_r, wstrb_r);
          pis_pkg::ADDR_SERIAL: serial_r <= merge(serial_r, wdata_r, wstrb_r);
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // read channel: data one edge after address
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pis_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= pis_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          pis_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_r;
          pis_pkg::ADDR_CFG: s_axi_rdata <= cfg_r;
          pis_pkg::ADDR_SERIAL: s_axi_rdata <= serial_r;
          pis_pkg::ADDR_STATUS: begin
            s_axi_rdata[pis_pkg::STAT_BUSY_BIT] <= seq_busy;
            s_axi_rdata[pis_pkg::STAT_DONE_BIT] <= seq_done;
            s_axi_rdata[pis_pkg::STAT_FIELD_LSB +: 6] <= field_r;
            s_axi_rdata[pis_pkg::STAT_REP_LSB +: 4] <= rep_r;
          end
          // unaligned or unmapped
          default: s_axi_rresp <= pis_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // sequence state: field, repeat, address/data phase
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= pis_pkg::PIS_IDLE;
      field_r <= pis_pkg::FLD_FIRST;
      rep_r <= 4'h0;
      k_r <= pis_pkg::K_ASYNC;
    end else if (ce) begin
      case (state_r)
        pis_pkg::PIS_IDLE: begin
          if (start_go) begin
            state_r <= pis_pkg::PIS_ID;
            field_r <= pis_pkg::FLD_FIRST;
            rep_r <= 4'h0;
            // k fixed for the whole run
            k_r <= ctrl_r[pis_pkg::CTRL_SYNC_BIT] ? pis_pkg::K_SYNC
                                                 : pis_pkg::K_ASYNC;
          end
        end
        pis_pkg::PIS_ID: begin
          if (slot_tick) begin
            state_r <= pis_pkg::PIS_DATA;
          end
        end
        pis_pkg::PIS_DATA: begin
          if (slot_tick) begin
            // pair repeats k times, then next field
            if (!last_rep) begin
              rep_r <= rep_r + 4'h1;
              state_r <= pis_pkg::PIS_ID;
            end else if (field_r == pis_pkg::FLD_LAST) begin
              rep_r <= 4'h0;
              state_r <= pis_pkg::PIS_IDLE;
            end else begin
              rep_r <= 4'h0;
              field_r <= field_r + 6'h01;
              state_r <= pis_pkg::PIS_ID;
            end
          end
        end
        default: state_r <= pis_pkg::PIS_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // data content; results sampled at the slot they go out in
  // ------------------------------------------------------------
  pis_nibble_mux #(
    .REV_HI(REV_HI),
    .REV_MID(REV_MID)
  ) u_mux (
    .field(field_r),
    .cfg(cfg_r),
    .serial(serial_r),
    .meas(meas),
    .ext_en(ext_en),
    .nibble(nibble)
  );

  // ------------------------------------------------------------
  // transmission outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx <= '0;
    end else if (ce) begin
      tx_valid <= tick_go;
      if (tick_go) begin
        tx.is_data <= (state_r == pis_pkg::PIS_DATA);
        tx.field <= field_r;
        tx.nibble <= (state_r == pis_pkg::PIS_DATA) ? nibble
                                                   : pis_pkg::nib_addr(field_r);
      end
    end
  end

  // ------------------------------------------------------------
  // busy and done flags
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_busy <= 1'b0;
      seq_done <= 1'b0;
    end else if (ce) begin
      if (start_go) begin
        seq_busy <= 1'b1;
        seq_done <= 1'b0;
      end else if (state_r == pis_pkg::PIS_DATA && slot_tick && last_rep &&
                   field_r == pis_pkg::FLD_LAST) begin
        seq_busy <= 1'b0;
        seq_done <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence data_slot(logic [5:0] f);
    ce && state_r == pis_pkg::PIS_DATA && slot_tick && field_r == f;
  endsequence

  sequence id_slot;
    ce && state_r == pis_pkg::PIS_ID && slot_tick;
  endsequence

  // any data tick, whatever the field
  sequence data_tick;
    ce && state_r == pis_pkg::PIS_DATA && slot_tick;
  endsequence

  chk_id_address: assert property (
    id_slot |=> tx_valid && !tx.is_data &&
      tx.nibble == pis_pkg::nib_addr($past(field_r)))
    else $error("address word carries wrong nibble address");

  // word standing before a data word must be its own address word
  chk_pair_order: assert property (
    data_tick |=> tx_valid && tx.is_data && tx.field == $past(field_r) &&
      !$past(tx.is_data) && $past(tx.field) == $past(field_r))
    else $error("data word does not follow its address word");

  chk_k_select: assert property (
    ce && start_go |=> k_r == ($past(ctrl_r[pis_pkg::CTRL_SYNC_BIT]) ?
      4'h4 : 4'h8))
    else $error("repeat count does not match mode");

  chk_ext_gate: assert property (
    data_slot(pis_pkg::FLD_OFS_HI) and !ext_en |=> tx.nibble == 4'h0)
    else $error("measured nibble sent with extension off");

  chk_st_unready: assert property (
    data_slot(pis_pkg::FLD_ST_HI) and !meas.st2_done |=> tx.nibble == 4'h0)
    else $error("unfinished self-test sent as nonzero");

  chk_offset_real: assert property (
    data_slot(pis_pkg::FLD_OFS_LO) and ext_en && meas.st1_done
      |=> tx.nibble == $past(meas.raw_offset[3:0]))
    else $error("finished offset not sent");

  chk_split_slot: assert property (
    data_slot(pis_pkg::FLD_OFS_ST) and ext_en && meas.st1_done &&
      meas.st2_done |=> tx.nibble == {$past(meas.average_selftest_value[1:0]),
      $past(meas.raw_offset[9:8])})
    else $error("shared offset and self-test slot wrong");

  chk_spec_nibble: assert property (
    data_slot(pis_pkg::FLD_LAST) and ext_en
      |=> tx.nibble == $past(cfg_r.device_config_byte_one[7:4]))
    else $error("sensor specific nibble wrong");

  chk_date_year: assert property (
    data_slot(pis_pkg::FLD_DATE0) |=> tx.nibble == $past(pis_pkg::julian_pack(
      cfg_r.device_config_byte_seven, cfg_r.device_config_byte_eight)) >> 12)
    else $error("year nibble wrong");

  chk_serial_first: assert property (
    data_slot(pis_pkg::FLD_SN_FIRST) |=> tx.nibble == $past(serial_r[7:4]))
    else $error("first serial nibble wrong");

endmodule : pis_sequencer

`default_nettype wire

// [dv/pis_receiver.sv]
// far-side model: paces transmission slots and collects the words
`timescale 1ns/1ps
`default_nettype none

module pis_receiver (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // slot pacing
  input wire logic en,
  input wire logic [3:0] gap,
  output logic slot_tick,
  // words from the sequencer
  input wire logic tx_valid,
  input wire pis_pkg::pis_tx_t tx
);
  logic [3:0] wait_r;  // idle slots left before next tick
  logic want_data = 1'b0;  // next word should carry data
  logic [5:0] prev_f = 6'h00;  // field of the last word seen
  int n_words = 0;  // words seen since time zero
  int n_bad = 0;  // order or address faults
  logic [3:0] data_nib [0:63];  // last data nibble per field

  // ------------------------------------------------------------
  // slot pacing
  // ------------------------------------------------------------
  // gap zero gives ticks back to back, the hardest case
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_tick <= 1'b0;
      wait_r <= 4'h0;
    end else if (en && wait_r == 4'h0) begin
      slot_tick <= 1'b1;
      wait_r <= gap;
    end else begin
      slot_tick <= 1'b0;
      wait_r <= (wait_r == 4'h0) ? 4'h0 : wait_r - 4'h1;
    end
  end

  // ------------------------------------------------------------
  // word collection
  // ------------------------------------------------------------
  // address word, then data word of the same field
  always @(posedge clk) begin
    if (!rst_n) begin
      want_data = 1'b0;
    end else if (tx_valid === 1'b1) begin
      n_words++;
      if (tx.is_data !== want_data) n_bad++;
      if (!want_data && tx.nibble !== 4'(tx.field - 6'h01)) n_bad++;
      if (want_data && tx.field !== prev_f) n_bad++;
      if (want_data) data_nib[tx.field] = tx.nibble;
      prev_f = tx.field;
      want_data = !want_data;
    end
  end
endmodule : pis_receiver

`default_nettype wire

// [dv/pis_sequencer_tb.sv]
// self-checking bench of the init phase 2 data sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %s expected %h seen %h", nm, e, g); \
  end end

module pis_sequencer_tb;
  localparam logic [3:0] REV_A = 4'ha;  // factory nibble, arbitrary
  localparam logic [3:0] REV_B = 4'h5;  // factory nibble, arbitrary
  // clock, reset and bus
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  // sequence side
  logic seq_start = 1'b0, rx_en = 1'b0, slot_tick, tx_valid;
  logic seq_busy, seq_done;
  logic [3:0] gap = 4'h0;
  pis_pkg::pis_meas_t meas = '0;
  pis_pkg::pis_tx_t tx;
  logic [31:0] cfg_w = 32'h2b17a51c, ser_w = 32'h89abcdef;
  int fail_count = 0, n_compared = 0;

  always #25 clk = ~clk;

  pis_sequencer #(.REV_HI(REV_A), .REV_MID(REV_B)) u_pis_sequencer (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .seq_start(seq_start), .slot_tick(slot_tick), .meas(meas),
    .tx_valid(tx_valid), .tx(tx), .seq_busy(seq_busy),
    .seq_done(seq_done));

  pis_receiver u_pis_receiver (
    .clk(clk), .rst_n(rst_n), .en(rx_en), .gap(gap),
    .slot_tick(slot_tick), .tx_valid(tx_valid), .tx(tx));

  // ------------------------------------------------------------
  // closing and bus tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic give_up();
    fail_count++;
    $display("Error wait expected answer seen none");
    test_done();
  endtask : give_up

  // address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 100) give_up();
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 100) give_up();
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // expected data nibble of a field, worked out independently
  function automatic logic [3:0] exp_nib(input int f, input logic ext);
    logic [15:0] dt;
    logic [9:0] o, a;
    dt = {3'h0, cfg_w[15:12], cfg_w[11:8], cfg_w[4:0]};
    o = meas.st1_done ? meas.raw_offset : 10'h000;
    a = meas.st2_done ? meas.average_selftest_value : 10'h000;
    if (f >= 27 && !ext) return 4'h0;
    case (f)
      12: return REV_A;
      13: return REV_B;
      14: return cfg_w[19:16];
      15: return dt[15:12];
      16: return dt[11:8];
      17: return dt[7:4];
      18: return dt[3:0];
      27: return o[3:0];
      28: return o[7:4];
      29: return {a[1:0], o[9:8]};
      30: return a[5:2];
      31: return a[9:6];
      32: return cfg_w[31:28];
      default: return ser_w[8 * ((f - 19) / 2) + ((f % 2) ? 4 : 0) +: 4];
    endcase
  endfunction : exp_nib

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // reset values, refused accesses, then the user configuration
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(pis_pkg::ADDR_CFG, d, r);
    `CHK("cfg reset", pis_pkg::CFG_RST, d)
    axi_rd(4'h2, d, r);
    `CHK("unaligned read", pis_pkg::RESP_SLVERR, r)
    axi_wr(pis_pkg::ADDR_STATUS, 32'hffffffff, r);
    `CHK("status write", pis_pkg::RESP_SLVERR, r)
    axi_wr(pis_pkg::ADDR_CFG, cfg_w, r);
    axi_wr(pis_pkg::ADDR_SERIAL, ser_w, r);
    axi_rd(pis_pkg::ADDR_SERIAL, d, r);
    `CHK("serial back", ser_w, d)
  endtask : t_regs

  // one whole run: start by pin or register, pace, judge every field
  task automatic t_run(input logic ext, input logic sync, input logic pin,
                       input logic [3:0] g);
    int i, n0, k;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] nb;
    k = sync ? 4 : 8;
    gap <= g;
    axi_wr(pis_pkg::ADDR_CTRL, {29'h0, !pin, sync, ext}, r);
    if (pin) begin
      seq_start <= 1'b1;
      @(posedge clk);
      seq_start <= 1'b0;
    end
    for (i = 0; i < 10 && seq_busy !== 1'b1; i++) @(posedge clk);
    if (i == 10) give_up();
    n0 = u_pis_receiver.n_words;
    rx_en <= 1'b1;
    for (i = 0; i < 4000 && seq_done !== 1'b1; i++) @(posedge clk);
    if (i == 4000) give_up();
    rx_en <= 1'b0;
    // let the model count the last word before reading its totals
    @(posedge clk);
    `CHK("tx words", 42 * k, u_pis_receiver.n_words - n0)
    `CHK("order faults", 0, u_pis_receiver.n_bad)
    for (i = 12; i <= 32; i++) begin
      nb = u_pis_receiver.data_nib[i];
      if (i >= 15 && i <= 18) begin
        `CHK("date nibble", exp_nib(i, ext), nb)
      end else if (i >= 27 && i <= 31) begin
        `CHK("result nibble", exp_nib(i, ext), nb)
      end else if (i == 32) begin
        `CHK("last nibble", exp_nib(i, ext), nb)
      end else begin
        `CHK("id nibble", exp_nib(i, ext), nb)
      end
    end
    axi_rd(pis_pkg::ADDR_STATUS, d, r);
    `CHK("status done", 2'b10, d[1:0])
  endtask : t_run

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    meas <= {10'h2c7, 10'h19e, 1'b1, 1'b1};
    // sync mode, back-to-back ticks, results ready
    t_run(1'b1, 1'b1, 1'b1, 4'h0);
    // offset unfinished: its nibbles must read zero
    meas <= {10'h2c7, 10'h19e, 1'b0, 1'b1};
    t_run(1'b1, 1'b0, 1'b0, 4'h2);
    // extension off: measured and last slots zero
    meas <= {10'h3a5, 10'h0f3, 1'b1, 1'b1};
    t_run(1'b0, 1'b1, 1'b0, 4'h1);
    test_done();
  end
endmodule : pis_sequencer_tb

`default_nettype wire
